// ==== core/ppi_pkg.sv ====
// Shared constants and types of the polled pattern interrupt matcher
package ppi_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] PPI_CTRL_OFF    = 8'h00;
  localparam logic [7:0] PPI_MASK_OFF    = 8'h04;
  localparam logic [7:0] PPI_CMP_OFF     = 8'h08;
  localparam logic [7:0] PPI_STATUS_OFF  = 8'h0C;
  localparam logic [7:0] PPI_IRQMASK_OFF = 8'h10;
  localparam logic [7:0] PPI_STATE_OFF   = 8'h14;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int PPI_CTRL_MODE_LSB = 0;
  localparam int PPI_CTRL_SRC_BIT  = 2;
  localparam int PPI_CTRL_PORT_LSB = 3;
  localparam int PPI_CTRL_ARM_BIT  = 8;
  localparam int PPI_CTRL_OFF_BIT  = 9;

  // ****************************************
  // State register fields
  // ****************************************
  localparam int PPI_ST_ENABLE_BIT  = 0;
  localparam int PPI_ST_PENDING_BIT = 1;
  localparam int PPI_ST_HANDLER_BIT = 2;
  localparam int PPI_ST_MATCH_BIT   = 3;
  localparam int PPI_ST_SRC_LSB     = 8;

  // ****************************************
  // Status event bits
  // ****************************************
  localparam int PPI_EV_W      = 3;
  localparam int PPI_EV_FIRE   = 0;
  localparam int PPI_EV_RETURN = 1;
  localparam int PPI_EV_ABORT  = 2;

  // ****************************************
  // Flag byte bit positions
  // ****************************************
  localparam int PPI_FLAG_HW_INT0 = 0;
  localparam int PPI_FLAG_HW_INT1 = 1;
  localparam int PPI_FLAG_HW_INT2 = 2;
  localparam int PPI_FLAG_HW_ANY  = 3;
  localparam int PPI_FLAG_COMP    = 4;
  localparam int PPI_FLAG_SERRX   = 5;
  localparam int PPI_FLAG_I2C     = 6;
  localparam int PPI_FLAG_TIMER   = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]        PPI_MASK_RST    = 8'h00;
  localparam logic [7:0]        PPI_CMP_RST     = 8'h00;
  localparam logic [PPI_EV_W-1:0] PPI_EVMASK_RST = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PPI_MODE_AND = 2'h0,
    PPI_MODE_OR  = 2'h1,
    PPI_MODE_NOT = 2'h2
  } ppi_mode_type;

  typedef enum logic [1:0] {
    PPI_PORT_A = 2'h0,
    PPI_PORT_B = 2'h1,
    PPI_PORT_C = 2'h2,
    PPI_PORT_D = 2'h3
  } ppi_port_type;

  typedef enum logic [1:0] {
    PPI_FSM_OFF        = 2'h0,
    PPI_FSM_ARMED      = 2'h1,
    PPI_FSM_HANDLER    = 2'h3,
    PPI_FSM_HANDLER_RA = 2'h2
  } ppi_fsm_type;

endpackage

// ==== core/ppi_match.sv ====
// Masked pattern comparator of the polled pattern interrupt matcher
`timescale 1ns/1ps
module ppi_match
  import ppi_pkg::*;
(
  input  wire logic [7:0]   src_i,
  input  wire logic [7:0]   cmp_i,
  input  wire logic [7:0]   mask_i,
  input  wire ppi_mode_type mode_i,
  output logic              match_o
);

  logic [7:0] same;

  // ****************************************
  // Bitwise agreement under the mask
  // ****************************************
  always_comb begin
    same = ~(src_i ^ cmp_i) | ~mask_i;
    case (mode_i)
      PPI_MODE_AND: match_o = &same;
      PPI_MODE_OR:  match_o = |(~(src_i ^ cmp_i) & mask_i);
      PPI_MODE_NOT: match_o = ~(&same);
      default:      match_o = &same;
    endcase
  end

endmodule

// ==== core/ppi_top.sv ====
// Top of the polled pattern interrupt matcher with its register slave
`timescale 1ns/1ps
module ppi_top
  import ppi_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [PORT_W-1:0] port_a_i,
  input  wire logic [PORT_W-1:0] port_b_i,
  input  wire logic [PORT_W-1:0] port_c_i,
  input  wire logic [PORT_W-1:0] port_d_i,
  input  wire logic              timer_overflow_flag_i,
  input  wire logic              i2c_slave_write_flag_i,
  input  wire logic              serial_rx_flag_i,
  input  wire logic              comparator_flag_i,
  input  wire logic              hw_any_pin_flag_i,
  input  wire logic              hw_int_two_flag_i,
  input  wire logic              hw_int_one_flag_i,
  input  wire logic              hw_int_zero_flag_i,
  input  wire logic              poll_i,
  input  wire logic              pause_active_i,
  input  wire logic              handler_return_i,
  output logic                   handler_call_o,
  output logic                   delay_abort_o,
  output logic                   irq_o
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
    $error("PORT_W must lie between 1 and 8");
  end

  localparam int SYNC_W = 4 * PORT_W;

  // ****************************************
  // State of the block
  // ****************************************
  typedef struct packed {
    logic [SYNC_W-1:0]   pin_s1;
    logic [SYNC_W-1:0]   pin_s2;
    logic [SYNC_W-1:0]   pin_s3;
    logic [SYNC_W-1:0]   pin_stable;
    logic [7:0]          mask;
    logic [7:0]          cmp;
    ppi_mode_type        mode;
    logic                src_flags;
    ppi_port_type        port_sel;
    ppi_fsm_type         fsm;
    logic [PPI_EV_W-1:0] status;
    logic [PPI_EV_W-1:0] ev_mask;
    logic                ack;
    logic [31:0]         rdata;
    logic                call;
    logic                abort;
    logic                irq;
  } ppi_regs_type;

  ppi_regs_type r_q;
  ppi_regs_type r_d;

  logic [7:0]          pin_byte;
  logic [7:0]          flag_byte;
  logic [7:0]          src_byte;
  logic                match;
  logic                fire;
  logic                bus_req;
  logic                wr_now;
  logic                rd_done;
  logic                arm_cmd;
  logic                off_cmd;
  logic [PPI_EV_W-1:0] events;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] port_pick(input logic [SYNC_W-1:0] ports,
                                           input ppi_port_type sel);
    logic [7:0] v;
    v = 8'h00;
    v[PORT_W-1:0] = ports[sel*PORT_W +: PORT_W];
    return v;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction

  function automatic logic is_enabled(input ppi_fsm_type s);
    return s == PPI_FSM_ARMED;
  endfunction

  function automatic logic [31:0] read_word(input ppi_regs_type s, input logic [7:0] adr,
                                            input logic m, input logic [7:0] src);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit(adr, PPI_CTRL_OFF)) begin
      w[PPI_CTRL_MODE_LSB +: 2] = s.mode;
      w[PPI_CTRL_SRC_BIT]       = s.src_flags;
      w[PPI_CTRL_PORT_LSB +: 2] = s.port_sel;
    end else if (hit(adr, PPI_MASK_OFF)) begin
      w[7:0] = s.mask;
    end else if (hit(adr, PPI_CMP_OFF)) begin
      w[7:0] = s.cmp;
    end else if (hit(adr, PPI_STATUS_OFF)) begin
      w[PPI_EV_W-1:0] = s.status;
    end else if (hit(adr, PPI_IRQMASK_OFF)) begin
      w[PPI_EV_W-1:0] = s.ev_mask;
    end else if (hit(adr, PPI_STATE_OFF)) begin
      w[PPI_ST_ENABLE_BIT]      = is_enabled(s.fsm);
      w[PPI_ST_PENDING_BIT]     = s.fsm == PPI_FSM_HANDLER_RA;
      w[PPI_ST_HANDLER_BIT]     = s.fsm == PPI_FSM_HANDLER || s.fsm == PPI_FSM_HANDLER_RA;
      w[PPI_ST_MATCH_BIT]       = m;
      w[PPI_ST_SRC_LSB +: 8]    = src;
    end
    return w;
  endfunction

  // ****************************************
  // Source selection and comparison
  // ****************************************
  always_comb begin
    flag_byte = 8'h00;
    flag_byte[PPI_FLAG_TIMER]   = timer_overflow_flag_i;
    flag_byte[PPI_FLAG_I2C]     = i2c_slave_write_flag_i;
    flag_byte[PPI_FLAG_SERRX]   = serial_rx_flag_i;
    flag_byte[PPI_FLAG_COMP]    = comparator_flag_i;
    flag_byte[PPI_FLAG_HW_ANY]  = hw_any_pin_flag_i;
    flag_byte[PPI_FLAG_HW_INT2] = hw_int_two_flag_i;
    flag_byte[PPI_FLAG_HW_INT1] = hw_int_one_flag_i;
    flag_byte[PPI_FLAG_HW_INT0] = hw_int_zero_flag_i;
    pin_byte = port_pick(r_q.pin_stable, r_q.port_sel);
    src_byte = r_q.src_flags ? flag_byte : pin_byte;
  end

  ppi_match u_match (
    .src_i   (src_byte),
    .cmp_i   (r_q.cmp),
    .mask_i  (r_q.mask),
    .mode_i  (r_q.mode),
    .match_o (match)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_now  = bus_req & wb_we_i & r_q.ack;
  assign rd_done = bus_req & ~wb_we_i & r_q.ack;
  assign arm_cmd = wr_now & hit(wb_adr_i, PPI_CTRL_OFF) & wb_sel_i[1] & wb_dat_i[PPI_CTRL_ARM_BIT];
  assign off_cmd = wr_now & hit(wb_adr_i, PPI_CTRL_OFF) & wb_sel_i[1] & wb_dat_i[PPI_CTRL_OFF_BIT];

  // Poll point or continuous check during a pause
  assign fire = is_enabled(r_q.fsm) & match & (poll_i | pause_active_i);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_d = r_q;

    // Pin synchroniser, value taken once stages two and three agree
    r_d.pin_s1 = {port_d_i, port_c_i, port_b_i, port_a_i};
    r_d.pin_s2 = r_q.pin_s1;
    r_d.pin_s3 = r_q.pin_s2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (r_q.pin_s2[i] == r_q.pin_s3[i]) begin
        r_d.pin_stable[i] = r_q.pin_s3[i];
      end
    end

    // Configuration writes
    if (wr_now && hit(wb_adr_i, PPI_CTRL_OFF) && wb_sel_i[0]) begin
      r_d.mode      = ppi_mode_type'(wb_dat_i[PPI_CTRL_MODE_LSB +: 2]);
      r_d.src_flags = wb_dat_i[PPI_CTRL_SRC_BIT];
      r_d.port_sel  = ppi_port_type'(wb_dat_i[PPI_CTRL_PORT_LSB +: 2]);
    end
    if (wr_now && hit(wb_adr_i, PPI_MASK_OFF) && wb_sel_i[0]) begin
      r_d.mask = wb_dat_i[7:0];
    end
    if (wr_now && hit(wb_adr_i, PPI_CMP_OFF) && wb_sel_i[0]) begin
      r_d.cmp = wb_dat_i[7:0];
    end
    if (wr_now && hit(wb_adr_i, PPI_IRQMASK_OFF) && wb_sel_i[0]) begin
      r_d.ev_mask = wb_dat_i[PPI_EV_W-1:0];
    end

    // Enable and handler tracking
    case (r_q.fsm)
      PPI_FSM_OFF: begin
        if (arm_cmd && !off_cmd) begin
          r_d.fsm = PPI_FSM_ARMED;
        end
      end
      PPI_FSM_ARMED: begin
        if (fire) begin
          r_d.fsm = (arm_cmd && !off_cmd) ? PPI_FSM_HANDLER_RA : PPI_FSM_HANDLER;
        end else if (off_cmd) begin
          r_d.fsm = PPI_FSM_OFF;
        end
      end
      PPI_FSM_HANDLER: begin
        if (handler_return_i) begin
          r_d.fsm = (arm_cmd && !off_cmd) ? PPI_FSM_ARMED : PPI_FSM_OFF;
        end else if (arm_cmd && !off_cmd) begin
          r_d.fsm = PPI_FSM_HANDLER_RA;
        end
      end
      PPI_FSM_HANDLER_RA: begin
        if (handler_return_i) begin
          r_d.fsm = off_cmd ? PPI_FSM_OFF : PPI_FSM_ARMED;
        end else if (off_cmd) begin
          r_d.fsm = PPI_FSM_HANDLER;
        end
      end
      default: begin
        r_d.fsm = PPI_FSM_OFF;
      end
    endcase

    // Sequencer strobes
    r_d.call  = fire;
    r_d.abort = fire & pause_active_i;

    // Sticky events, set wins over read clear
    events = '0;
    events[PPI_EV_FIRE]   = fire;
    events[PPI_EV_RETURN] = handler_return_i &
                            (r_q.fsm == PPI_FSM_HANDLER || r_q.fsm == PPI_FSM_HANDLER_RA);
    events[PPI_EV_ABORT]  = fire & pause_active_i;
    if (rd_done && hit(wb_adr_i, PPI_STATUS_OFF)) begin
      // Clear only the bits handed out with the read data
      r_d.status = (r_q.status & ~r_q.rdata[PPI_EV_W-1:0]) | events;
    end else begin
      r_d.status = r_q.status | events;
    end
    r_d.irq = |(r_d.status & r_d.ev_mask);

    // Bus answer one cycle after the request
    r_d.ack   = bus_req & ~r_q.ack;
    r_d.rdata = (bus_req && !wb_we_i && !r_q.ack) ?
                read_word(r_q, wb_adr_i, match, src_byte) : 32'h0000_0000;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q            <= '0;
      r_q.mask       <= PPI_MASK_RST;
      r_q.cmp        <= PPI_CMP_RST;
      r_q.mode       <= PPI_MODE_AND;
      r_q.port_sel   <= PPI_PORT_C;
      r_q.fsm        <= PPI_FSM_OFF;
      r_q.ev_mask    <= PPI_EVMASK_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o       = r_q.ack;
  assign wb_dat_o       = r_q.rdata;
  assign handler_call_o = r_q.call;
  assign delay_abort_o  = r_q.abort;
  assign irq_o          = r_q.irq;

endmodule

// ==== dv/ppi_top_chk.sv ====
// Bound checker of the polled pattern interrupt matcher
`timescale 1ns/1ps
module ppi_top_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        poll_i,
  input wire logic        pause_active_i,
  input wire logic        handler_call_o,
  input wire logic        delay_abort_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_call_single: assert property (handler_call_o |=> !handler_call_o)
    else $error("handler call repeated");
  chk_call_cause: assert property (handler_call_o |-> $past(poll_i || pause_active_i))
    else $error("handler call without poll point");
  chk_abort_pair: assert property (delay_abort_o |-> handler_call_o && $past(pause_active_i))
    else $error("abort without call in pause");
  chk_abort_whole: assert property (handler_call_o && $past(pause_active_i) |-> delay_abort_o)
    else $error("call in pause without abort");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !handler_call_o [*3])
    else $error("handler call right after reset");
endmodule

bind ppi_top ppi_top_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .poll_i,
  .pause_active_i, .handler_call_o, .delay_abort_o);

// ==== dv/ppi_seq_model.sv ====
// Sequencer model driving poll points, pauses and handler returns
`timescale 1ns/1ps
module ppi_seq_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       poll_en_i,
  input  wire logic       pause_req_i,
  input  wire logic [7:0] ret_dly_i,
  input  wire logic       call_i,
  input  wire logic       abort_i,
  output logic            poll_o,
  output logic            pause_o,
  output logic            ret_o
);
  // ****************************************
  // Sequencer
  // ****************************************
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  logic       busy_q;
  logic       cut_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q   <= 2'h0;
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
      cut_q  <= 1'b0;
      ret_o  <= 1'b0;
    end else begin
      ph_q  <= ph_q + 2'h1;
      ret_o <= 1'b0;
      if (call_i) begin
        busy_q <= 1'b1;
        cnt_q  <= ret_dly_i;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        ret_o  <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
      if (abort_i) begin
        cut_q <= 1'b1;
      end else if (!pause_req_i) begin
        cut_q <= 1'b0;
      end
    end
  end

  assign poll_o  = poll_en_i && ph_q == 2'h0 && !rst_i;
  assign pause_o = pause_req_i && !cut_q;
endmodule

// ==== dv/test_polled_pattern_interrupt.sv ====
// Testbench of the polled pattern interrupt matcher
`timescale 1ns/1ps
module test_polled_pattern_interrupt
  import ppi_pkg::*;
;
  // ****************************************
  // Bench
  // ****************************************
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [7:0]  port_a_i = 8'h11, port_b_i = 8'h22, port_c_i = 8'h00, port_d_i = 8'h44, flg = 8'h00;
  logic        poll_en = 1'b0, pause_req = 1'b0, poll_i, pause_active_i, handler_return_i;
  logic        wb_ack_o, handler_call_o, delay_abort_o, irq_o;
  int          fail_count = 0, n_compared = 0, ncall = 0, nabort = 0, i;
  logic [31:0] tab [8] = '{32'h00808480, 32'h00808484, 32'h0000005A, 32'h01818101, 32'h0181817E,
                           32'h02808480, 32'h02FFFFFE, 32'h03808484};
  logic [7:0]  pv [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

  ppi_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .port_a_i, .port_b_i, .port_c_i, .port_d_i, .timer_overflow_flag_i(flg[7]),
    .i2c_slave_write_flag_i(flg[6]), .serial_rx_flag_i(flg[5]), .comparator_flag_i(flg[4]),
    .hw_any_pin_flag_i(flg[3]), .hw_int_two_flag_i(flg[2]), .hw_int_one_flag_i(flg[1]),
    .hw_int_zero_flag_i(flg[0]), .poll_i, .pause_active_i, .handler_return_i, .handler_call_o,
    .delay_abort_o, .irq_o);
  ppi_seq_model i_seq (.clk_i, .rst_i, .poll_en_i(poll_en), .pause_req_i(pause_req), .ret_dly_i(8'h28),
    .call_i(handler_call_o), .abort_i(delay_abort_o), .poll_o(poll_i), .pause_o(pause_active_i),
    .ret_o(handler_return_i));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ncall += (handler_call_o === 1'b1);
    nabort += (delay_abort_o === 1'b1);
  end

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask

  function automatic logic hit(logic [1:0] m, logic [7:0] c, logic [7:0] k, logic [7:0] s);
    if (m == 2'h1) return |(~(c ^ s) & k);
    hit = ((c ^ s) & k) == 8'h00;
    if (m == 2'h2) hit = !hit;
  endfunction

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(PPI_CTRL_OFF, 32'h10, "ctrl");
    rd_chk(PPI_MASK_OFF, 32'h0, "mask");
    rd_chk(PPI_CMP_OFF, 32'h0, "compare");
    rd_chk(PPI_IRQMASK_OFF, 32'h0, "irq mask");
    rd_chk(PPI_STATE_OFF, 32'h08, "state");
    rd_chk(8'h18, 32'h0, "unmapped");
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      port_c_i <= tab[i][7:0];
      bus(1'b1, PPI_MASK_OFF, tab[i][15:8]);
      bus(1'b1, PPI_CMP_OFF, tab[i][23:16]);
      bus(1'b1, PPI_CTRL_OFF, {27'h0, 2'h2, 1'b0, tab[i][25:24]});
      repeat (4) @(posedge clk_i);
      rd_chk(PPI_MASK_OFF, {24'h0, tab[i][15:8]}, "mask");
      rd_chk(PPI_STATE_OFF, {16'h0, tab[i][7:0], 4'h0, hit(tab[i][25:24], tab[i][23:16], tab[i][15:8],
        tab[i][7:0]), 3'h0}, "match");
    end
    $display("test match done");
    port_c_i <= 8'h33;
    bus(1'b1, PPI_MASK_OFF, 32'h0);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, PPI_CTRL_OFF, i << 3);
      repeat (4) @(posedge clk_i);
      rd_chk(PPI_STATE_OFF, {16'h0, pv[i], 8'h08}, "port");
    end
    bus(1'b1, PPI_CTRL_OFF, 32'h4);
    for (i = 0; i < 8; i++) begin
      flg <= 8'h01 << i;
      repeat (3) @(posedge clk_i);
      rd_chk(PPI_STATE_OFF, {16'h0, 8'h01 << i, 8'h08}, "flag");
    end
    flg <= 8'h00;
    $display("test source done");
    port_a_i <= 8'hF5;
    bus(1'b1, PPI_MASK_OFF, 32'h0F);
    bus(1'b1, PPI_CMP_OFF, 32'h05);
    bus(1'b1, PPI_IRQMASK_OFF, 32'h7);
    poll_en <= 1'b1;
    bus(1'b1, PPI_CTRL_OFF, 32'h100);
    for (i = 0; i < 20 && ncall == 0; i++) @(posedge clk_i);
    chk("call", 1, ncall);
    rd_chk(PPI_STATE_OFF, 32'hF50C, "in handler");
    chk("irq", 1, irq_o);
    rd_chk(PPI_STATUS_OFF, 32'h1, "status fire");
    bus(1'b1, PPI_CTRL_OFF, 32'h100);
    rd_chk(PPI_STATE_OFF, 32'hF50E, "pending");
    chk("irq cleared", 0, irq_o);
    chk("no early fire", 1, ncall);
    for (i = 0; i < 80 && ncall < 2; i++) @(posedge clk_i);
    chk("refire", 2, ncall);
    repeat (100) @(posedge clk_i);
    chk("disarmed", 2, ncall);
    rd_chk(PPI_STATUS_OFF, 32'h3, "status return");
    $display("test fire done");
    poll_en <= 1'b0;
    port_a_i <= 8'h00;
    pause_req <= 1'b1;
    bus(1'b1, PPI_IRQMASK_OFF, 32'h0);
    bus(1'b1, PPI_CTRL_OFF, 32'h100);
    repeat (20) @(posedge clk_i);
    chk("no match", 2, ncall);
    rd_chk(PPI_STATE_OFF, 32'h0001, "armed");
    bus(1'b1, PPI_CTRL_OFF, 32'h200);
    port_a_i <= 8'h05;
    repeat (20) @(posedge clk_i);
    chk("off", 2, ncall);
    rd_chk(PPI_STATE_OFF, 32'h0508, "off state");
    bus(1'b1, PPI_CTRL_OFF, 32'h100);
    for (i = 0; i < 20 && ncall < 3; i++) @(posedge clk_i);
    chk("pause fire", 3, ncall);
    chk("abort", 1, nabort);
    chk("irq masked", 0, irq_o);
    pause_req <= 1'b0;
    repeat (60) @(posedge clk_i);
    rd_chk(PPI_STATUS_OFF, 32'h7, "status abort");
    $display("test pause done");
    bus(1'b1, PPI_CTRL_OFF, 32'h100);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(PPI_MASK_OFF, 32'h0, "mask after reset");
    rd_chk(PPI_CMP_OFF, 32'h0, "compare after reset");
    rd_chk(PPI_CTRL_OFF, 32'h10, "ctrl after reset");
    rd_chk(PPI_STATE_OFF, 32'h3308, "state after reset");
    $display("test reset again done");
    summarize();
  end
endmodule
